// ### svs_pkg.sv
// package: register map, field positions and timing for the slave verification status block
package svs_pkg;
	// word indices of the registers; the byte address is four times the index
	localparam int unsigned IDX_REG_TBL_OUT = 0;
	localparam int unsigned IDX_REG_TBL_IN  = 1;
	localparam int unsigned IDX_MON_TIME    = 2;
	localparam int unsigned IDX_NET_STATUS  = 4;
	localparam int unsigned IDX_STOP_CAUSE  = 5;
	localparam int unsigned IDX_MISS_OUT    = 6;
	localparam int unsigned IDX_MISS_IN     = 7;
	localparam int unsigned IDX_UNREG_OUT   = 8;
	localparam int unsigned IDX_UNREG_IN    = 9;
	localparam int unsigned IDX_CTRL        = 10;
	localparam int unsigned IDX_IRQ_STATUS  = 11;
	localparam int unsigned IDX_IRQ_MASK    = 12;
	localparam logic [11:0] ADDR_REG_TBL_OUT = 12'(IDX_REG_TBL_OUT * 4);
	localparam logic [11:0] ADDR_REG_TBL_IN  = 12'(IDX_REG_TBL_IN * 4);
	localparam logic [11:0] ADDR_MON_TIME    = 12'(IDX_MON_TIME * 4);
	localparam logic [11:0] ADDR_NET_STATUS  = 12'(IDX_NET_STATUS * 4);
	localparam logic [11:0] ADDR_STOP_CAUSE  = 12'(IDX_STOP_CAUSE * 4);
	localparam logic [11:0] ADDR_MISS_OUT    = 12'(IDX_MISS_OUT * 4);
	localparam logic [11:0] ADDR_MISS_IN     = 12'(IDX_MISS_IN * 4);
	localparam logic [11:0] ADDR_UNREG_OUT   = 12'(IDX_UNREG_OUT * 4);
	localparam logic [11:0] ADDR_UNREG_IN    = 12'(IDX_UNREG_IN * 4);
	localparam logic [11:0] ADDR_CTRL        = 12'(IDX_CTRL * 4);
	localparam logic [11:0] ADDR_IRQ_STATUS  = 12'(IDX_IRQ_STATUS * 4);
	localparam logic [11:0] ADDR_IRQ_MASK    = 12'(IDX_IRQ_MASK * 4);
	// network status word fields
	localparam int unsigned BIT_REG_DONE  = 0;
	localparam int unsigned BIT_MISSING   = 8;
	localparam int unsigned BIT_UNREG     = 9;
	localparam int unsigned BIT_STOPPED   = 10;
	localparam int unsigned BIT_ERROR     = 15;
	// stop cause word fields
	localparam int unsigned BIT_STOP_TYPE = 15;
	localparam int unsigned NODE_W        = 8;
	// control register field
	localparam int unsigned BIT_STOP_MODE = 0;
	// interrupt status bits
	localparam int unsigned IRQ_REG_DONE = 0;
	localparam int unsigned IRQ_MISSING  = 1;
	localparam int unsigned IRQ_UNREG    = 2;
	localparam int unsigned IRQ_STOPPED  = 3;
	localparam int unsigned IRQ_W        = 4;
	// monitoring time
	localparam logic [15:0] MON_TIME_RESET   = 16'h0000;
	localparam logic [15:0] MON_TIME_MAX     = 16'hFFDC;
	localparam logic [15:0] MON_DEFAULT_MS   = 16'h07D0; // 2000 ms
	localparam int unsigned CLK_HZ           = 125_000_000;
	localparam int unsigned MS_PER_S         = 1000;
	localparam int unsigned CYCLES_PER_MS    = CLK_HZ / MS_PER_S;
endpackage

// ### svs_ms_tick.sv
// module: millisecond enable divider
`timescale 1ns/1ns
module svs_ms_tick #(
	parameter int unsigned CYCLES = svs_pkg::CYCLES_PER_MS
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic clr,
	output logic      tick
);
	logic [31:0] cnt_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 32'h0000_0000;
			tick  <= 1'b0;
		end else if (clr) begin
			cnt_q <= 32'h0000_0000;
			tick  <= 1'b0;
		end else if (cnt_q == 32'(CYCLES - 1)) begin
			cnt_q <= 32'h0000_0000;
			tick  <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'h0000_0001;
			tick  <= 1'b0;
		end
	end
endmodule

// ### slave_verification_status.sv
// module: slave registration verification and communications-stop status words
//
// The APB register port was decided locally.
`timescale 1ns/1ns
module slave_verification_status #(
	parameter int unsigned MS_CYCLES = svs_pkg::CYCLES_PER_MS
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [15:0] joined_out,
	input  wire logic [15:0] joined_in,
	input  wire logic        comm_error,
	input  wire logic [3:0]  err_node,
	input  wire logic        err_is_input,
	output logic             irq
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MON_WAIT  = 2'b00,
		MON_CHECK = 2'b01
	} mon_state_t;

	mon_state_t  state_q;
	logic [15:0] tbl_out_q, tbl_in_q, mon_time_q;
	logic        stop_mode_q;
	logic [15:0] elapsed_q;
	logic        done_q, unreg_q, stopped_q;
	logic [15:0] miss_out_q, miss_in_q, unreg_out_q, unreg_in_q;
	localparam int unsigned NODE_W_L = svs_pkg::NODE_W;
	logic [NODE_W_L-1:0] stop_node_q;
	logic        stop_type_q;
	logic [svs_pkg::IRQ_W-1:0] irq_sts_q, irq_mask_q, irq_evt;
	logic        ms_tick, wr_en, rd_en, addr_ok;
	logic [15:0] limit_ms, net_status, stop_cause;
	logic [15:0] unreg_out_now, unreg_in_now;
	logic        missing;

	// write lands on the completing edge only, so a w1c clear cannot hit a fresh event
	assign wr_en = psel && penable && pwrite && pready;
	assign rd_en = psel && !penable && !pwrite;

	// divider idles once the window has closed; nothing counts milliseconds after it
	svs_ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
		.pclk    (pclk),
		.presetn (presetn),
		.clr     (state_q == MON_CHECK),
		.tick    (ms_tick)
	);

	// ------------------------------------------------------------
	// monitoring window
	// ------------------------------------------------------------
	assign limit_ms = (mon_time_q == svs_pkg::MON_TIME_RESET) ? svs_pkg::MON_DEFAULT_MS :
		(mon_time_q > svs_pkg::MON_TIME_MAX) ? svs_pkg::MON_TIME_MAX : mon_time_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q   <= MON_WAIT;
			elapsed_q <= 16'h0000;
		end else begin
			unique case (state_q)
				MON_WAIT: begin
					if (ms_tick) begin
						elapsed_q <= elapsed_q + 16'h0001;
						if (elapsed_q + 16'h0001 >= limit_ms) begin
							state_q <= MON_CHECK;
						end
					end
				end
				MON_CHECK: begin
					state_q <= MON_CHECK;
				end
				default: state_q <= MON_WAIT;
			endcase
		end
	end

	// ------------------------------------------------------------
	// verification flags
	// ------------------------------------------------------------
	assign unreg_out_now = joined_out & ~tbl_out_q;
	assign unreg_in_now  = joined_in & ~tbl_in_q;
	assign missing       = (miss_out_q | miss_in_q) != 16'h0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_q <= 1'b0;
		end else if (state_q == MON_WAIT && (tbl_out_q | tbl_in_q) != 16'h0000
			&& (tbl_out_q & ~joined_out) == 16'h0000
			&& (tbl_in_q & ~joined_in) == 16'h0000) begin
			done_q <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			miss_out_q <= 16'h0000;
			miss_in_q  <= 16'h0000;
		end else if (state_q == MON_CHECK) begin
			// only nodes still absent stay flagged; a join drops the bit
			miss_out_q <= miss_out_q & ~joined_out;
			miss_in_q  <= miss_in_q & ~joined_in;
		end else if (ms_tick && elapsed_q + 16'h0001 >= limit_ms) begin
			miss_out_q <= tbl_out_q & ~joined_out;
			miss_in_q  <= tbl_in_q & ~joined_in;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unreg_out_q <= 16'h0000;
			unreg_in_q  <= 16'h0000;
			unreg_q     <= 1'b0;
		end else begin
			unreg_out_q <= unreg_out_q | unreg_out_now;
			unreg_in_q  <= unreg_in_q | unreg_in_now;
			if ((unreg_out_now | unreg_in_now) != 16'h0000) begin
				unreg_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stopped_q   <= 1'b0;
			stop_node_q <= '0;
			stop_type_q <= 1'b0;
		end else if (stop_mode_q && comm_error && !stopped_q) begin
			// first fault is kept; later faults do not overwrite it
			stopped_q   <= 1'b1;
			stop_node_q <= {4'h0, err_node};
			stop_type_q <= err_is_input;
		end
	end

	assign net_status = {(missing | unreg_q | stopped_q), 4'h0, stopped_q, unreg_q, missing,
		7'h00, done_q};
	assign stop_cause = {stop_type_q, 7'h00, stop_node_q};

	// ------------------------------------------------------------
	// interrupts
	// ------------------------------------------------------------
	assign irq_evt = {(stop_mode_q && comm_error && !stopped_q),
		((unreg_out_now | unreg_in_now) != 16'h0000 && !unreg_q),
		(state_q == MON_WAIT && ms_tick && elapsed_q + 16'h0001 >= limit_ms
			&& ((tbl_out_q & ~joined_out) | (tbl_in_q & ~joined_in)) != 16'h0000),
		(!done_q && state_q == MON_WAIT && (tbl_out_q | tbl_in_q) != 16'h0000
			&& (tbl_out_q & ~joined_out) == 16'h0000 && (tbl_in_q & ~joined_in) == 16'h0000)};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_sts_q <= '0;
		end else if (wr_en && paddr == svs_pkg::ADDR_IRQ_STATUS) begin
			// set wins over a write-one clear in the same cycle
			irq_sts_q <= (irq_sts_q & ~pwdata[svs_pkg::IRQ_W-1:0]) | irq_evt;
		end else begin
			irq_sts_q <= irq_sts_q | irq_evt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= (irq_sts_q & irq_mask_q) != '0;
		end
	end

	// ------------------------------------------------------------
	// apb writes
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tbl_out_q   <= 16'h0000;
			tbl_in_q    <= 16'h0000;
			mon_time_q  <= svs_pkg::MON_TIME_RESET;
			stop_mode_q <= 1'b0;
			irq_mask_q  <= '0;
		end else if (wr_en) begin
			unique case (paddr)
				svs_pkg::ADDR_REG_TBL_OUT: tbl_out_q <= pwdata[15:0];
				svs_pkg::ADDR_REG_TBL_IN:  tbl_in_q <= pwdata[15:0];
				svs_pkg::ADDR_MON_TIME:    mon_time_q <= pwdata[15:0];
				svs_pkg::ADDR_CTRL:        stop_mode_q <= pwdata[svs_pkg::BIT_STOP_MODE];
				svs_pkg::ADDR_IRQ_MASK:    irq_mask_q <= pwdata[svs_pkg::IRQ_W-1:0];
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// apb reads: data registered in setup, ready in access
	// ------------------------------------------------------------
	always_comb begin
		addr_ok = 1'b1;
		unique case (paddr)
			svs_pkg::ADDR_REG_TBL_OUT, svs_pkg::ADDR_REG_TBL_IN, svs_pkg::ADDR_MON_TIME,
			svs_pkg::ADDR_NET_STATUS, svs_pkg::ADDR_STOP_CAUSE, svs_pkg::ADDR_MISS_OUT,
			svs_pkg::ADDR_MISS_IN, svs_pkg::ADDR_UNREG_OUT, svs_pkg::ADDR_UNREG_IN,
			svs_pkg::ADDR_CTRL, svs_pkg::ADDR_IRQ_STATUS, svs_pkg::ADDR_IRQ_MASK: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			unique case (paddr)
				svs_pkg::ADDR_REG_TBL_OUT: prdata <= {16'h0000, tbl_out_q};
				svs_pkg::ADDR_REG_TBL_IN:  prdata <= {16'h0000, tbl_in_q};
				svs_pkg::ADDR_MON_TIME:    prdata <= {16'h0000, mon_time_q};
				svs_pkg::ADDR_NET_STATUS:  prdata <= {16'h0000, net_status};
				svs_pkg::ADDR_STOP_CAUSE:  prdata <= {16'h0000, stop_cause};
				svs_pkg::ADDR_MISS_OUT:    prdata <= {16'h0000, miss_out_q};
				svs_pkg::ADDR_MISS_IN:     prdata <= {16'h0000, miss_in_q};
				svs_pkg::ADDR_UNREG_OUT:   prdata <= {16'h0000, unreg_out_q};
				svs_pkg::ADDR_UNREG_IN:    prdata <= {16'h0000, unreg_in_q};
				svs_pkg::ADDR_CTRL:        prdata <= {31'h0000_0000, stop_mode_q};
				svs_pkg::ADDR_IRQ_STATUS:  prdata <= {28'h000_0000, irq_sts_q};
				svs_pkg::ADDR_IRQ_MASK:    prdata <= {28'h000_0000, irq_mask_q};
				default:                   prdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			// one wait state: every access ends on the second access-phase edge
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !addr_ok;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_empty_never_done;
		@(posedge pclk) disable iff (!presetn)
		(tbl_out_q == 16'h0000 && tbl_in_q == 16'h0000 && !done_q) |=> !done_q;
	endproperty
	a_empty_never_done: assert property (p_empty_never_done)
		else $error("done set, empty table");

	property p_done_sticky;
		@(posedge pclk) disable iff (!presetn) done_q |=> done_q;
	endproperty
	a_done_sticky: assert property (p_done_sticky) else $error("completed flag dropped");

	property p_unreg_set;
		@(posedge pclk) disable iff (!presetn)
		((joined_out & ~tbl_out_q) != 16'h0000) |=> unreg_q && net_status[9];
	endproperty
	a_unreg_set: assert property (p_unreg_set) else $error("unregistered flag missed");

	property p_unreg_sticky;
		@(posedge pclk) disable iff (!presetn) unreg_q |=> unreg_q;
	endproperty
	a_unreg_sticky: assert property (p_unreg_sticky) else $error("unregistered flag dropped");

	sequence s_stop_evt;
		stop_mode_q && comm_error && !stopped_q;
	endsequence
	property p_stop_capture;
		@(posedge pclk) disable iff (!presetn)
		s_stop_evt |=> stopped_q && stop_node_q == {4'h0, $past(err_node)}
			&& stop_type_q == $past(err_is_input);
	endproperty
	a_stop_capture: assert property (p_stop_capture) else $error("stop cause not captured");

	property p_stopped_sticky;
		@(posedge pclk) disable iff (!presetn) stopped_q |=> stopped_q && $stable(stop_node_q);
	endproperty
	a_stopped_sticky: assert property (p_stopped_sticky) else $error("stop status changed");

	property p_no_stop_without_mode;
		@(posedge pclk) disable iff (!presetn) (!stop_mode_q && !stopped_q) |=> !stopped_q;
	endproperty
	a_no_stop_without_mode: assert property (p_no_stop_without_mode)
		else $error("stop w/o mode");

	property p_summary;
		@(posedge pclk) disable iff (!presetn)
		net_status[15] == (net_status[8] | net_status[9] | net_status[10]);
	endproperty
	a_summary: assert property (p_summary) else $error("summary flag wrong");

	property p_miss_clear;
		@(posedge pclk) disable iff (!presetn)
		(state_q == MON_CHECK && ((miss_out_q & joined_out) == miss_out_q)
			&& ((miss_in_q & joined_in) == miss_in_q)) |=> !missing;
	endproperty
	a_miss_clear: assert property (p_miss_clear) else $error("missing flag not cleared");

	sequence s_window_end;
		state_q == MON_WAIT && ms_tick && elapsed_q + 16'h0001 >= limit_ms;
	endsequence
	sequence s_reg_absent;
		((tbl_out_q & ~joined_out) | (tbl_in_q & ~joined_in)) != 16'h0000;
	endsequence
	property p_miss_set;
		@(posedge pclk) disable iff (!presetn)
		s_window_end ##0 s_reg_absent |=> missing && net_status[8] && state_q == MON_CHECK;
	endproperty
	a_miss_set: assert property (p_miss_set) else $error("missing flag not set");
endmodule

// ### slave_nodes.sv
// slave-node model: join/leave with a settable delay, and comms faults
`timescale 1ns/1ns
module slave_nodes (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [15:0] want_out,
	input  wire logic [15:0] want_in,
	input  wire logic [7:0]  delay,
	input  wire logic        fault,
	input  wire logic [3:0]  fault_node,
	input  wire logic        fault_in,
	output logic      [15:0] joined_out,
	output logic      [15:0] joined_in,
	output logic             comm_error,
	output logic      [3:0]  err_node,
	output logic             err_is_input
);
	logic [7:0] wait_q;

	// slow slaves: membership changes only after delay cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_q <= 8'h00;
			joined_out <= 16'h0000;
			joined_in <= 16'h0000;
		end else if ((want_out != joined_out) || (want_in != joined_in)) begin
			if (wait_q >= delay) begin
				joined_out <= want_out;
				joined_in <= want_in;
				wait_q <= 8'h00;
			end else begin
				wait_q <= wait_q + 8'h01;
			end
		end
	end

	// node and type are only meaningful with the error; toggle them otherwise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comm_error <= 1'b0;
			err_node <= 4'h0;
			err_is_input <= 1'b0;
		end else begin
			comm_error <= fault;
			err_node <= fault ? fault_node : ~err_node;
			err_is_input <= fault ? fault_in : ~err_is_input;
		end
	end
endmodule

// ### testbench.sv
// testbench: status words checked over APB against a slave-node model
`timescale 1ns/1ns
module testbench;
	typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} note_t;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic        comm_error, err_is_input, fault, fault_in;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] joined_out, joined_in, want_out, want_in;
	logic [7:0]  delay;
	logic [3:0]  err_node, fault_node, k;
	int          cyc, n_mismatch, comparisons, u;
	note_t       q[$];
	note_t       nt;

	slave_verification_status #(.MS_CYCLES(2)) slave_verification_status_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.joined_out(joined_out), .joined_in(joined_in), .comm_error(comm_error),
		.err_node(err_node), .err_is_input(err_is_input), .irq(irq));
	slave_nodes slave_nodes_inst (
		.pclk(pclk), .presetn(presetn), .want_out(want_out), .want_in(want_in),
		.delay(delay), .fault(fault), .fault_node(fault_node), .fault_in(fault_in),
		.joined_out(joined_out), .joined_in(joined_in), .comm_error(comm_error),
		.err_node(err_node), .err_is_input(err_is_input));

	// ----------------------------------------
	// clock, cycle count, checking
	// ----------------------------------------
	always #4 pclk = ~pclk;
	always @(posedge pclk or negedge presetn) cyc <= presetn ? cyc + 1 : 0;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// every completed transfer takes the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			nt = q.pop_front();
			check(prdata & nt.m, nt.d);
			check({31'h0, pslverr}, {31'h0, nt.e});
		end
	end

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		#(8 * 20000);
		n_mismatch++;
		test_done();
	end

	// ----------------------------------------
	// bus and sequencing tasks
	// ----------------------------------------
	// idle cycle after each transfer keeps psel from being driven twice in one step
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
			input logic [31:0] m, input logic e);
		int n;
		q.push_back('{d & m, m, e});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (n >= 40) n_mismatch++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 32'h0000_0000, 1'b0);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] d,
			input logic [31:0] m = 32'hFFFF_FFFF);
		xfer(1'b0, a, d, m, 1'b0);
	endtask

	task automatic do_reset();
		presetn <= 1'b0;
		want_out <= 16'h0000;
		want_in <= 16'h0000;
		fault <= 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	task automatic wait_to(input int n);
		while (cyc < n) @(posedge pclk);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		{want_out, want_in, delay, fault, fault_node, fault_in} = '0;
		n_mismatch = 0;
		comparisons = 0;
		cyc = 0;
		void'($urandom(32'hdaae));
		u = 8 + ($urandom % 8);
		k = 4'($urandom % 16);
		// default window (2000 ms), slow slaves, one unregistered and two missing
		do_reset();
		rd(svs_pkg::ADDR_NET_STATUS, 32'h0000_0000);
		rd(svs_pkg::ADDR_STOP_CAUSE, 32'h0000_0000);
		delay <= 8'h03;
		wr(svs_pkg::ADDR_REG_TBL_OUT, 32'h0000_0006);
		wr(svs_pkg::ADDR_REG_TBL_IN, 32'h0000_0010);
		wr(svs_pkg::ADDR_IRQ_MASK, 32'h0000_0008);
		want_out <= 16'h0002 | (16'h0001 << u);
		wait_to(60);
		rd(svs_pkg::ADDR_NET_STATUS, 32'h0000_8200);
		rd(svs_pkg::ADDR_UNREG_OUT, 32'h0000_0001 << u);
		rd(svs_pkg::ADDR_UNREG_IN, 32'h0000_0000);
		check({31'h0, irq}, 32'h0000_0000);
		// fault without stop mode must not stop anything
		fault <= 1'b1;
		fault_node <= k;
		fault_in <= 1'b1;
		repeat (4) @(posedge pclk);
		fault <= 1'b0;
		rd(svs_pkg::ADDR_NET_STATUS, 32'h0000_8200);
		wr(svs_pkg::ADDR_CTRL, 32'h0000_0001);
		fault <= 1'b1;
		repeat (4) @(posedge pclk);
		fault_node <= ~k;
		fault_in <= 1'b0;
		repeat (4) @(posedge pclk);
		fault <= 1'b0;
		rd(svs_pkg::ADDR_NET_STATUS, 32'h0000_8600);
		rd(svs_pkg::ADDR_STOP_CAUSE, {16'h0000, 12'h800, k});
		check({31'h0, irq}, 32'h0000_0001);
		wr(svs_pkg::ADDR_IRQ_STATUS, 32'h0000_0008);
		rd(svs_pkg::ADDR_IRQ_STATUS, 32'h0000_0004);
		check({31'h0, irq}, 32'h0000_0000);
		xfer(1'b0, 12'h3FC, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
		wr(svs_pkg::ADDR_NET_STATUS, 32'hFFFF_FFFF);
		rd(svs_pkg::ADDR_NET_STATUS, 32'h0000_8600);
		// default window is 2000 ms, 4000 cycles here: still open just before its end
		wait_to(3980);
		rd(svs_pkg::ADDR_NET_STATUS, 32'h0000_8600);
		wait_to(4100);
		rd(svs_pkg::ADDR_NET_STATUS, 32'h0000_8700);
		rd(svs_pkg::ADDR_MISS_OUT, 32'h0000_0004);
		rd(svs_pkg::ADDR_MISS_IN, 32'h0000_0010);
		want_out <= 16'h0006 | (16'h0001 << u);
		want_in <= 16'h0010;
		repeat (10) @(posedge pclk);
		rd(svs_pkg::ADDR_MISS_OUT, 32'h0000_0000);
		rd(svs_pkg::ADDR_MISS_IN, 32'h0000_0000);
		rd(svs_pkg::ADDR_NET_STATUS, 32'h0000_8600);
		want_out <= 16'h0006;
		repeat (10) @(posedge pclk);
		rd(svs_pkg::ADDR_NET_STATUS, 32'h0000_8600);
		rd(svs_pkg::ADDR_UNREG_OUT, 32'h0000_0001 << u);
		// prompt slaves complete the table, then leave
		do_reset();
		delay <= 8'h00;
		wr(svs_pkg::ADDR_REG_TBL_OUT, 32'h0000_0001);
		wr(svs_pkg::ADDR_MON_TIME, 32'h0000_0020);
		wr(svs_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
		want_out <= 16'h0001;
		want_in <= 16'h0004;
		wait_to(30);
		rd(svs_pkg::ADDR_NET_STATUS, 32'h0000_8201);
		rd(svs_pkg::ADDR_UNREG_IN, 32'h0000_0004);
		check({31'h0, irq}, 32'h0000_0001);
		want_out <= 16'h0000;
		want_in <= 16'h0000;
		wait_to(200);
		rd(svs_pkg::ADDR_NET_STATUS, 32'h0000_0001, 32'h0000_0001);
		// short window of 32 ms with an absent input slave
		do_reset();
		wr(svs_pkg::ADDR_REG_TBL_IN, 32'h0000_8000);
		wr(svs_pkg::ADDR_MON_TIME, 32'h0000_0020);
		wait_to(50);
		rd(svs_pkg::ADDR_NET_STATUS, 32'h0000_0000, 32'h0000_0100);
		wait_to(80);
		rd(svs_pkg::ADDR_NET_STATUS, 32'h0000_0100, 32'h0000_0100);
		rd(svs_pkg::ADDR_MISS_IN, 32'h0000_8000);
		// empty table never completes
		do_reset();
		wr(svs_pkg::ADDR_MON_TIME, 32'h0000_0001);
		want_out <= 16'h0003;
		wait_to(40);
		rd(svs_pkg::ADDR_NET_STATUS, 32'h0000_0000, 32'h0000_0001);
		// stop caused by an output slave records type zero
		wr(svs_pkg::ADDR_CTRL, 32'h0000_0001);
		fault_node <= ~k;
		fault_in <= 1'b0;
		fault <= 1'b1;
		repeat (4) @(posedge pclk);
		fault <= 1'b0;
		rd(svs_pkg::ADDR_STOP_CAUSE, {16'h0000, 12'h000, ~k});
		rd(svs_pkg::ADDR_NET_STATUS, 32'h0000_8600, 32'h0000_8400);
		test_done();
	end
endmodule
